// ### rtl/wct_pkg.sv
// Purpose: constants shared by the watchdog and capture timer block
// Assumes: AXI4-Lite with 32-bit data, byte addresses as below
// Notes: gp timer control bits [6:0] are a local layout
`default_nettype none
package wct_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [31:0] ADDR_WD_LOAD = 32'hFFFF0360;
  localparam logic [31:0] ADDR_WD_VALUE = 32'hFFFF0364;
  localparam logic [31:0] ADDR_WD_CTRL = 32'hFFFF0368;
  localparam logic [31:0] ADDR_WD_REFRESH = 32'hFFFF036C;
  localparam logic [31:0] ADDR_GP_LOAD = 32'hFFFF0380;
  localparam logic [31:0] ADDR_GP_COUNT = 32'hFFFF0384;
  localparam logic [31:0] ADDR_GP_CTRL = 32'hFFFF0388;
  localparam logic [31:0] ADDR_GP_CLEAR = 32'hFFFF038C;
  localparam logic [31:0] ADDR_GP_CAPTURE = 32'hFFFF0390;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFF0394;
  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] WD_CTRL_RESET = 16'h0000;
  localparam logic [15:0] WD_CTRL_MASK = 16'h01FF;
  localparam logic [15:0] WD_LOAD_RESET = 16'hFFFF;
  localparam logic [31:0] GP_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] GP_CTRL_MASK = 32'h0003F07F;
  localparam logic [31:0] GP_LOAD_RESET = 32'h00000000;
  // ==========================================================
  // watchdog control fields
  localparam int WD_UP = 8;
  localparam int WD_EN = 7;
  localparam int WD_PERIODIC = 6;
  localparam int WD_WDOG = 5;
  localparam int WD_SECURE = 4;
  localparam int WD_PRE_LO = 2;
  localparam int WD_IRQ = 1;
  localparam int WD_STOP_IN_POWERDOWN = 0;
  // ==========================================================
  // gp timer control fields
  localparam int GP_CAP_EN = 17;
  localparam int GP_SEL_LO = 12;
  localparam int GP_EN = 6;
  localparam int GP_UP = 5;
  localparam int GP_TOD = 4;
  localparam int GP_PRE_LO = 2;
  localparam int GP_SRC_LO = 0;
  // ==========================================================
  // prescaler terminal counts, time-of-day limits
  localparam logic [14:0] DIV1_MAX = 15'h0000;
  localparam logic [14:0] DIV16_MAX = 15'h000F;
  localparam logic [14:0] DIV256_MAX = 15'h00FF;
  localparam logic [14:0] DIV32K_MAX = 15'h7FFF;
  localparam logic [7:0] HUND_MAX = 8'h63;
  localparam logic [7:0] SEC_MAX = 8'h3B;
  localparam logic [7:0] MIN_MAX = 8'h3B;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SRC_OSC = 2'h0,
    SRC_CORE = 2'h1,
    SRC_PLL = 2'h2,
    SRC_EXT = 2'h3
  } wct_src_e;
endpackage : wct_pkg
`default_nettype wire

// ### rtl/wct_timers.sv
// Purpose: watchdog timer and 32-bit capture timer behind AXI4-Lite
// Assumes: one clock sys_clk at 125 MHz, async active-high reset rst
// Notes: oscillator and external pins are synchronised before use
`timescale 1ns/1ns
`default_nettype none
// Function
// - any refresh register write reloads the watchdog counter
// - watchdog control accepts one write after reset, reads always allowed
// - watchdog control bit 8 set counts up, cleared counts down
// - watchdog control bit 7 enables counting, cleared halts it
// - watchdog control bit 6 picks periodic, cleared picks free running
// - watchdog control bit 5 turns watchdog behaviour on
// - watchdog control bit 4 turns the secure refresh option on
// - watchdog prescaler bits 3:2 code 00 divides 32.768 kHz by one
// - watchdog bit 1 makes expiry raise an interrupt instead of reset
// - watchdog bit 0 stops the timer while peripherals are powered down
// - gp timer is 32-bit up/down with osc, core, PLL or external source
// - gp prescaler divides by 1, 16, 256 or 32768
// - gp count is plain binary or hours, minutes, seconds, hundredths
// - first assertion of chosen event copies count to capture, keeps counting
// - gp control bit 17 enables capture, bits 16:12 pick the event
// - load, count, capture are 32-bit; count and capture read-only
// - any write to gp clear register clears the gp interrupt unless an overflow sets it in that cycle
// - gp counter reloads from load on overflow and on clear write
// - in low power gp timer keeps counting on osc or external source
module wct_timers import wct_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock sources and power state
  input wire logic osc32kPin,
  input wire logic extClkPin,
  input wire logic pllTick,
  input wire logic periphPowerDown,
  input wire logic lowPower,
  // capture event sources
  input wire logic [31:0] eventIn,
  // timer outputs
  output logic wdResetReq,
  output logic wdIrq,
  output logic gpIrq
);
  // ==========================================================
  // secure refresh key, arbitrary value
  localparam logic [7:0] REFRESH_KEY = 8'hA5;

  // ==========================================================
  // pin synchronisers and tick edges
  logic oscS1_q, oscS2_q, oscS3_q, extS1_q, extS2_q, extS3_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oscS1_q <= 1'b0;
      oscS2_q <= 1'b0;
      oscS3_q <= 1'b0;
      extS1_q <= 1'b0;
      extS2_q <= 1'b0;
      extS3_q <= 1'b0;
    end else begin
      oscS1_q <= osc32kPin;
      oscS2_q <= oscS1_q;
      oscS3_q <= oscS2_q;
      extS1_q <= extClkPin;
      extS2_q <= extS1_q;
      extS3_q <= extS2_q;
    end
  end
  logic oscTick, extTick;
  assign oscTick = oscS2_q & ~oscS3_q;
  assign extTick = extS2_q & ~extS3_q;

  // ==========================================================
  // axi write channel
  logic awHeld_q, wHeld_q;
  logic [31:0] awAddr_q, wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  logic wrHit;
  assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 32'h00000000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  logic wrWdLoad, wrWdCtrl, wrWdRefresh, wrGpLoad, wrGpCtrl, wrGpClear;
  always_comb begin
    wrWdLoad = doWrite && awAddr_q == ADDR_WD_LOAD;
    wrWdCtrl = doWrite && awAddr_q == ADDR_WD_CTRL;
    wrWdRefresh = doWrite && awAddr_q == ADDR_WD_REFRESH;
    wrGpLoad = doWrite && awAddr_q == ADDR_GP_LOAD;
    wrGpCtrl = doWrite && awAddr_q == ADDR_GP_CTRL;
    wrGpClear = doWrite && awAddr_q == ADDR_GP_CLEAR;
    wrHit = wrWdLoad | wrWdCtrl | wrWdRefresh | wrGpLoad | wrGpCtrl |
      wrGpClear | (awAddr_q == ADDR_WD_VALUE) |
      (awAddr_q == ADDR_GP_COUNT) | (awAddr_q == ADDR_GP_CAPTURE) |
      (awAddr_q == ADDR_STATUS);
  end

  // ==========================================================
  // watchdog registers
  logic [15:0] wdCtrl_q, wdLoad_q, wdCount_q;
  logic wdCtrlDone_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdCtrl_q <= WD_CTRL_RESET;
      wdCtrlDone_q <= 1'b0;
    end else if (wrWdCtrl && !wdCtrlDone_q) begin
      wdCtrl_q <= 16'(merge({16'h0000, wdCtrl_q}, wData_q, wStrb_q))
        & WD_CTRL_MASK;
      wdCtrlDone_q <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdLoad_q <= WD_LOAD_RESET;
    end else if (wrWdLoad) begin
      wdLoad_q <= 16'(merge({16'h0000, wdLoad_q}, wData_q, wStrb_q));
    end
  end

  // ==========================================================
  // watchdog counter
  logic wdTick, wdWrap, wdExpire, wdBadKey;
  logic [15:0] wdNext;
  // prescaler bits are not decoded: every code divides by one
  assign wdTick = oscTick && wdCtrl_q[WD_EN]
    && !(wdCtrl_q[WD_STOP_IN_POWERDOWN] && periphPowerDown);
  always_comb begin
    if (wdCtrl_q[WD_UP]) begin
      wdWrap = wdCount_q == 16'hFFFF;
      wdNext = wdCount_q + 16'h0001;
    end else begin
      wdWrap = wdCount_q == 16'h0000;
      wdNext = wdCount_q - 16'h0001;
    end
  end
  // secure refresh: a wrong key counts as an immediate expiry
  assign wdBadKey = wrWdRefresh && wdCtrl_q[WD_SECURE]
    && wStrb_q[0] && wData_q[7:0] != REFRESH_KEY;
  assign wdExpire = wdCtrl_q[WD_WDOG] && ((wdTick && wdNext == 16'h0000)
    || wdBadKey);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdCount_q <= 16'h0000;
    end else if (wrWdRefresh) begin
      wdCount_q <= wdLoad_q;
    end else if (wdTick) begin
      if (wdExpire || (wdWrap && wdCtrl_q[WD_PERIODIC])) begin
        wdCount_q <= wdLoad_q;
      end else begin
        wdCount_q <= wdNext;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdResetReq <= 1'b0;
      wdIrq <= 1'b0;
    end else begin
      wdResetReq <= wdExpire && !wdCtrl_q[WD_IRQ];
      if (wdExpire && wdCtrl_q[WD_IRQ]) begin
        wdIrq <= 1'b1;
      end else if (wrWdRefresh) begin
        wdIrq <= 1'b0;
      end
    end
  end

  // ==========================================================
  // gp timer registers
  logic [31:0] gpCtrl_q, gpLoad_q, gpCount_q, gpCap_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpCtrl_q <= GP_CTRL_RESET;
      gpLoad_q <= GP_LOAD_RESET;
    end else begin
      if (wrGpCtrl) begin
        gpCtrl_q <= merge(gpCtrl_q, wData_q, wStrb_q) & GP_CTRL_MASK;
      end
      if (wrGpLoad) begin
        gpLoad_q <= merge(gpLoad_q, wData_q, wStrb_q);
      end
    end
  end

  // ==========================================================
  // gp clock source and prescaler
  logic [1:0] gpSrc, gpPre;
  logic srcTick, gpTick;
  logic [14:0] pre_q, preMax;
  assign gpSrc = gpCtrl_q[GP_SRC_LO +: 2];
  assign gpPre = gpCtrl_q[GP_PRE_LO +: 2];
  always_comb begin
    unique case (wct_src_e'(gpSrc))
      SRC_OSC: srcTick = oscTick;
      SRC_CORE: srcTick = !lowPower;
      SRC_PLL: srcTick = pllTick && !lowPower;
      SRC_EXT: srcTick = extTick;
    endcase
    unique case (gpPre)
      2'h0: preMax = DIV1_MAX;
      2'h1: preMax = DIV16_MAX;
      2'h2: preMax = DIV256_MAX;
      2'h3: preMax = DIV32K_MAX;
    endcase
  end
  assign gpTick = srcTick && pre_q >= preMax;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 15'h0000;
    end else if (!gpCtrl_q[GP_EN] || wrGpClear) begin
      pre_q <= 15'h0000;
    end else if (srcTick) begin
      pre_q <= gpTick ? 15'h0000 : pre_q + 15'h0001;
    end
  end

  // ==========================================================
  // time-of-day step: fields hours, minutes, seconds, hundredths
  function automatic logic [32:0] todStep(input logic [31:0] v,
      input logic up);
    logic [7:0] lim [4];
    logic [31:0] r;
    logic carry;
    lim[0] = HUND_MAX;
    lim[1] = SEC_MAX;
    lim[2] = MIN_MAX;
    lim[3] = HOUR_MAX;
    r = v;
    carry = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (carry) begin
        if (up) begin
          carry = r[i*8 +: 8] >= lim[i];
          r[i*8 +: 8] = carry ? 8'h00 : r[i*8 +: 8] + 8'h01;
        end else begin
          carry = r[i*8 +: 8] == 8'h00;
          r[i*8 +: 8] = carry ? lim[i] : r[i*8 +: 8] - 8'h01;
        end
      end
    end
    return {carry, r};
  endfunction : todStep

  // ==========================================================
  // gp counter
  logic [32:0] gpStep;
  always_comb begin
    if (gpCtrl_q[GP_TOD]) begin
      gpStep = todStep(gpCount_q, gpCtrl_q[GP_UP]);
    end else if (gpCtrl_q[GP_UP]) begin
      gpStep = {1'b0, gpCount_q} + 33'h000000001;
    end else begin
      gpStep = {gpCount_q == 32'h00000000, gpCount_q - 32'h00000001};
    end
  end
  logic gpOvf;
  assign gpOvf = gpCtrl_q[GP_EN] && gpTick && gpStep[32];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpCount_q <= 32'h00000000;
    end else if (wrGpClear || gpOvf) begin
      gpCount_q <= gpLoad_q;
    end else if (gpCtrl_q[GP_EN] && gpTick) begin
      gpCount_q <= gpStep[31:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpIrq <= 1'b0;
    end else if (gpOvf) begin
      gpIrq <= 1'b1;
    end else if (wrGpClear) begin
      gpIrq <= 1'b0;
    end
  end

  // ==========================================================
  // event capture on first assertion of the chosen source
  logic [31:0] evtPrev_q;
  logic [4:0] evtSel;
  assign evtSel = gpCtrl_q[GP_SEL_LO +: 5];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      evtPrev_q <= 32'h00000000;
      gpCap_q <= 32'h00000000;
    end else begin
      evtPrev_q <= eventIn;
      if (gpCtrl_q[GP_CAP_EN] && eventIn[evtSel]
          && !evtPrev_q[evtSel]) begin
        gpCap_q <= gpCount_q;
      end
    end
  end

  // ==========================================================
  // axi read channel
  logic [31:0] rdMux;
  logic rdHit;
  always_comb begin
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_WD_LOAD: rdMux = {16'h0000, wdLoad_q};
      ADDR_WD_VALUE: rdMux = {16'h0000, wdCount_q};
      ADDR_WD_CTRL: rdMux = {16'h0000, wdCtrl_q};
      ADDR_GP_LOAD: rdMux = gpLoad_q;
      ADDR_GP_COUNT: rdMux = gpCount_q;
      ADDR_GP_CTRL: rdMux = gpCtrl_q;
      ADDR_GP_CAPTURE: rdMux = gpCap_q;
      ADDR_STATUS: rdMux = {29'h00000000, wdCtrlDone_q, gpIrq, wdIrq};
      ADDR_WD_REFRESH, ADDR_GP_CLEAR: rdMux = 32'h00000000;
      default: begin
        rdMux = 32'h00000000;
        rdHit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : wct_timers
`default_nettype wire

// ### bench/wct_timers_asserts.sv
// Purpose: port-level checks of the watchdog and capture timer block
// Assumes: single clock sys_clk, async active-high reset rst
// Notes: attached to every wct_timers instance by the bind below
`timescale 1ns/1ns
`default_nettype none
module wct_timers_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer outputs
  input wire logic wdResetReq,
  input wire logic wdIrq,
  input wire logic gpIrq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // register bus
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write accepted while busy");
  // ==========================================================
  // timer outputs
  a_reset_pulse: assert property (wdResetReq |=> !wdResetReq)
    else $error("reset request wider than one cycle");
  a_irq_not_reset: assert property ($rose(wdIrq) |-> !wdResetReq)
    else $error("interrupt and reset together");
  a_gp_irq_clear: assert property ($fell(gpIrq) |-> $rose(s_axi_bvalid))
    else $error("gp interrupt dropped without a write");
  a_wd_irq_clear: assert property ($fell(wdIrq) |-> $rose(s_axi_bvalid))
    else $error("wd interrupt dropped without a write");
  c_reset_req: cover property (wdResetReq);
  c_gp_irq: cover property ($rose(gpIrq));
  c_wd_irq: cover property ($rose(wdIrq));
  c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule : wct_timers_asserts
bind wct_timers wct_timers_asserts u_chk (.sys_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .wdResetReq, .wdIrq, .gpIrq);
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for the watchdog and capture timers
// Assumes: AXI4-Lite master tasks, pin ticks made by the bench
// Notes: gp timer runs from the external pin for exact counts
`timescale 1ns/1ns
`default_nettype none
module tb import wct_pkg::*;;
  localparam logic [31:0] EXTDN = (32'h1 << GP_EN) | 32'(SRC_EXT);
  localparam logic [31:0] EXTUP = EXTDN | (32'h1 << GP_UP);
  localparam logic [31:0] CAPT = EXTUP | (32'h1 << GP_CAP_EN) |
    (32'h5 << GP_SEL_LO);
  localparam logic [31:0] WDI = 32'h00A2;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, eventIn;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic osc32kPin, extClkPin, pllTick, periphPowerDown, lowPower;
  logic wdResetReq, wdIrq, gpIrq;
  int n_errors, num_checks, nReset;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [31:0] ra [5] = '{ADDR_WD_CTRL, ADDR_GP_LOAD, ADDR_GP_COUNT,
    ADDR_GP_CTRL, ADDR_GP_CAPTURE};

  wct_timers dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .osc32kPin, .extClkPin, .pllTick,
    .periphPowerDown, .lowPower, .eventIn, .wdResetReq, .wdIrq, .gpIrq);

  // ==========================================================
  // clock, pulse counter, hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (wdResetReq === 1'b1) nReset++;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic rc(input string nm, input logic [31:0] a, exp);
    rd(a);
    chk(nm, rv, exp);
    chk("rresp", {30'h0, rr}, {30'h0, RESP_OKAY});
  endtask : rc

  task automatic tick(input bit ext, input int n);
    repeat (n) begin
      if (ext) extClkPin <= 1'b1;
      else osc32kPin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      if (ext) extClkPin <= 1'b0;
      else osc32kPin <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask : tick

  task automatic gp(input logic [31:0] ld, ct, input int n);
    wr(ADDR_GP_LOAD, ld);
    wr(ADDR_GP_CTRL, ct);
    wr(ADDR_GP_CLEAR, 32'h0);
    tick(1'b1, n);
  endtask : gp

  task automatic ev(input int b);
    eventIn <= 32'h1 << b;
    repeat (2) @(posedge sys_clk);
    eventIn <= 32'h0;
    @(posedge sys_clk);
  endtask : ev

  task automatic do_reset;
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // ==========================================================
  // tests
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'hF;
    {s_axi_arvalid, s_axi_rready, osc32kPin, extClkPin} = 4'h0;
    {pllTick, periphPowerDown, lowPower} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    eventIn = 32'h0;
    do_reset();
    foreach (ra[i]) rc("reset value", ra[i], 32'h0);
    rd(32'hFFFF0370);
    chk("unmapped rresp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(32'hFFFF0370, 32'h1, RESP_SLVERR);
    wr(ADDR_GP_COUNT, 32'h55);
    rc("count read only", ADDR_GP_COUNT, 32'h0);
    gp(32'h100, EXTUP, 5);
    rc("count up", ADDR_GP_COUNT, 32'h105);
    gp(32'h100, EXTDN, 3);
    rc("count down", ADDR_GP_COUNT, 32'hFD);
    gp(32'h100, EXTUP | (32'h1 << GP_PRE_LO), 32);
    rc("prescale 16", ADDR_GP_COUNT, 32'h102);
    gp(32'hFFFFFFFE, EXTUP, 2);
    rc("overflow reload", ADDR_GP_COUNT, 32'hFFFFFFFE);
    chk("gp irq set", {31'h0, gpIrq}, 32'h1);
    wr(ADDR_GP_CLEAR, 32'h0);
    chk("gp irq clear", {31'h0, gpIrq}, 32'h0);
    gp(32'h63, EXTUP | (32'h1 << GP_TOD), 1);
    rc("time of day", ADDR_GP_COUNT, 32'h100);
    lowPower <= 1'b1;
    gp(32'h10, EXTUP, 2);
    rc("low power ext", ADDR_GP_COUNT, 32'h12);
    wr(ADDR_GP_CTRL, (32'h1 << GP_EN) | 32'(SRC_CORE));
    wr(ADDR_GP_CLEAR, 32'h0);
    rc("low power core", ADDR_GP_COUNT, 32'h10);
    wr(ADDR_GP_CTRL, 32'h0);
    lowPower <= 1'b0;
    gp(32'h200, CAPT, 3);
    ev(4);
    rc("other event", ADDR_GP_CAPTURE, 32'h0);
    ev(5);
    rc("capture", ADDR_GP_CAPTURE, 32'h203);
    tick(1'b1, 1);
    rc("keeps counting", ADDR_GP_COUNT, 32'h204);
    wr(ADDR_WD_LOAD, 32'h3);
    wr(ADDR_WD_CTRL, WDI);
    wr(ADDR_WD_REFRESH, 32'h0);
    tick(1'b0, 2);
    rc("wd down", ADDR_WD_VALUE, 32'h1);
    tick(1'b0, 1);
    chk("wd irq", {31'h0, wdIrq}, 32'h1);
    chk("no reset", nReset, 32'h0);
    rc("wd reload", ADDR_WD_VALUE, 32'h3);
    wr(ADDR_WD_CTRL, 32'h0);
    rc("ctrl once", ADDR_WD_CTRL, WDI);
    wr(ADDR_WD_REFRESH, 32'h5A);
    chk("wd irq clear", {31'h0, wdIrq}, 32'h0);
    do_reset();
    wr(ADDR_WD_LOAD, 32'h2);
    wr(ADDR_WD_CTRL, 32'h00A1);
    wr(ADDR_WD_REFRESH, 32'h0);
    periphPowerDown <= 1'b1;
    tick(1'b0, 3);
    rc("power down stop", ADDR_WD_VALUE, 32'h2);
    periphPowerDown <= 1'b0;
    tick(1'b0, 1);
    wr(ADDR_WD_REFRESH, 32'h0);
    tick(1'b0, 1);
    chk("refresh holds off", nReset, 32'h0);
    tick(1'b0, 1);
    chk("wd reset", nReset, 32'h1);
    do_reset();
    wr(ADDR_WD_LOAD, 32'h2);
    wr(ADDR_WD_CTRL, 32'h00C0);
    rc("status", ADDR_STATUS, 32'h4);
    wr(ADDR_WD_REFRESH, 32'h0);
    tick(1'b0, 3);
    rc("periodic reload", ADDR_WD_VALUE, 32'h2);
    do_reset();
    wr(ADDR_WD_CTRL, 32'h00B0);
    wr(ADDR_WD_REFRESH, 32'h0);
    chk("bad key resets", nReset, 32'h2);
    end_sim();
  end
endmodule : tb
`default_nettype wire
